//--- src/tsp_pkg.sv
// Package holding register offsets, field positions and selector codes.
`default_nettype none
package tsp_pkg;
  localparam logic [7:0] TSP_ADDR_PIN_CONFIG = 8'h02;
  localparam logic [7:0] TSP_ADDR_SIGNAL_SELECT = 8'h0B;
  localparam logic [7:0] TSP_ADDR_PIN_ONE_DRIVE = 8'h4F;
  localparam logic [15:0] TSP_PIN_CONFIG_RESET = 16'h0000;
  localparam logic [15:0] TSP_SIGNAL_SELECT_RESET = 16'h0000;
  localparam logic [15:0] TSP_PIN_ONE_DRIVE_RESET = 16'h0000;
  localparam int TSP_POL0_BIT = 0;
  localparam int TSP_STYLE0_BIT = 1;
  localparam int TSP_EN0_BIT = 2;
  localparam int TSP_POL1_BIT = 8;
  localparam int TSP_STYLE1_BIT = 9;
  localparam int TSP_EN1_BIT = 6;
  localparam int TSP_SEL0_LSB = 0;
  localparam int TSP_SEL1_LSB = 8;
  localparam int TSP_SEL_W = 5;
  localparam logic [4:0] TSP_SEL_INTERRUPT = 5'h01;
  localparam logic [4:0] TSP_SEL_SAMPLE_WINDOW = 5'h02;
  localparam logic [4:0] TSP_SEL_LED_A = 5'h05;
  localparam logic [4:0] TSP_SEL_LED_B = 5'h06;
  localparam logic [4:0] TSP_SEL_LED_AB = 5'h07;
  localparam logic [4:0] TSP_SEL_WRITTEN_A = 5'h0C;
  localparam logic [4:0] TSP_SEL_WRITTEN_B = 5'h0D;
  localparam logic [4:0] TSP_SEL_WRITTEN_AB = 5'h0E;
  localparam logic [4:0] TSP_SEL_HALF_RATE = 5'h0F;
  localparam logic [4:0] TSP_SEL_LOGIC_ZERO = 5'h10;
  localparam logic [4:0] TSP_SEL_LOGIC_ONE = 5'h11;
  localparam logic [4:0] TSP_SEL_OSC = 5'h13;
endpackage
`default_nettype wire

//--- src/tsp_sig_if.sv
// Interface carrying internal timing signals between the sequencer and pins.
`default_nettype none
interface tsp_sig_if;
  logic irq;
  logic legacy_secondary_output;
  logic window;
  logic led_a;
  logic led_b;
  logic written_a;
  logic written_b;
  logic half_rate_toggle;
  logic osc;
  modport src(output irq, legacy_secondary_output, window, led_a, led_b,
    written_a, written_b, half_rate_toggle, osc);
  modport dst(input irq, legacy_secondary_output, window, led_a, led_b,
    written_a, written_b, half_rate_toggle, osc);
endinterface
`default_nettype wire

//--- src/tsp_pin_drive.sv
// One timing pin: signal selection, polarity and drive style.
`default_nettype none
module tsp_pin_drive
  import tsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  tsp_sig_if.dst sig,
  input wire logic [4:0] sel,
  input wire logic legacy,
  input wire logic legacy_is_pin_one,
  input wire logic polarity_low,
  input wire logic open_drain,
  input wire logic drive_en,
  output logic pin_out,
  output logic pin_oe_n
);
  logic asserted;
  logic level;
  logic next_pin_out;
  logic next_pin_oe_n;

  always_comb begin
    if (legacy) begin
      // Legacy mode: pin zero carries the interrupt, pin one the other.
      asserted = legacy_is_pin_one ? sig.legacy_secondary_output
                                   : sig.irq;
    end else begin
      case (sel)
        TSP_SEL_INTERRUPT: asserted = sig.irq;
        TSP_SEL_SAMPLE_WINDOW: asserted = sig.window;
        TSP_SEL_LED_A: asserted = sig.led_a;
        TSP_SEL_LED_B: asserted = sig.led_b;
        TSP_SEL_LED_AB: asserted = sig.led_a | sig.led_b;
        TSP_SEL_WRITTEN_A: asserted = sig.written_a;
        TSP_SEL_WRITTEN_B: asserted = sig.written_b;
        TSP_SEL_WRITTEN_AB: asserted = sig.written_a | sig.written_b;
        TSP_SEL_HALF_RATE: asserted = sig.half_rate_toggle;
        TSP_SEL_LOGIC_ZERO: asserted = 1'b0;
        TSP_SEL_LOGIC_ONE: asserted = 1'b1;
        TSP_SEL_OSC: asserted = sig.osc;
        default: asserted = 1'b0;
      endcase
    end
    // Release is taken before polarity, so open drain releases whenever not asserted.
    level = asserted ^ polarity_low;
    next_pin_out = level;
    if (!drive_en) begin
      next_pin_oe_n = 1'b1;
    end else if (open_drain) begin
      next_pin_oe_n = !asserted;
    end else begin
      next_pin_oe_n = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pin_out <= 1'b0;
      pin_oe_n <= 1'b1;
    end else begin
      pin_out <= next_pin_out;
      pin_oe_n <= next_pin_oe_n;
    end
  end

  property p_disabled_released;
    @(posedge clk) disable iff (rst)
      !drive_en |=> pin_oe_n;
  endproperty
  a_disabled_released: assert property (p_disabled_released)
    else $error("Pin driven while its drive is disabled.");

  property p_open_drain_release;
    @(posedge clk) disable iff (rst)
      (drive_en && open_drain && !legacy && sel == TSP_SEL_LOGIC_ZERO)
        |=> pin_oe_n;
  endproperty
  a_open_drain_release: assert property (p_open_drain_release)
    else $error("Open drain pin driven while deasserted.");

  property p_const_one;
    @(posedge clk) disable iff (rst)
      (!legacy && sel == TSP_SEL_LOGIC_ONE)
        |=> pin_out == !$past(polarity_low);
  endproperty
  a_const_one: assert property (p_const_one)
    else $error("Constant one selection shows the wrong level.");

  property p_undefined_inactive;
    @(posedge clk) disable iff (rst)
      (!legacy && sel == 5'h1F) |=> pin_out == $past(polarity_low);
  endproperty
  a_undefined_inactive: assert property (p_undefined_inactive)
    else $error("Undefined selection does not sit inactive.");
endmodule
`default_nettype wire

//--- src/tsp_timing_pins.sv
// Timing signal pin selector top with its register file and sequencing.
`default_nettype none
module tsp_timing_pins
  import tsp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  input wire logic normal_mode,
  input wire logic sample_start,
  input wire logic slot_a_active,
  input wire logic slot_b_active,
  input wire logic slot_a_end,
  input wire logic slot_b_end,
  input wire logic led_a_pulse,
  input wire logic led_b_pulse,
  input wire logic data_stored_a,
  input wire logic data_stored_b,
  input wire logic irq_masked,
  input wire logic legacy_secondary_output,
  input wire logic osc_32k_pin,
  output logic timing_pin_zero_out,
  output logic timing_pin_zero_oe_n,
  output logic timing_pin_one_out,
  output logic timing_pin_one_oe_n
);
  logic [15:0] timing_pin_config;
  logic [15:0] timing_signal_select;
  logic [15:0] pin_one_drive_control;
  logic [15:0] next_timing_pin_config;
  logic [15:0] next_timing_signal_select;
  logic [15:0] next_pin_one_drive_control;
  logic [15:0] next_reg_rdata;
  logic osc_meta;
  logic osc_sync;
  logic written_a;
  logic written_b;
  logic half_rate;
  logic normal_q;
  logic next_written_a;
  logic next_written_b;
  logic next_half_rate;
  logic legacy;
  logic [4:0] sel_zero;
  logic [4:0] sel_one;
  tsp_sig_if sig();

  // Register file: writes steer the pins, reads return stored values.
  always_comb begin
    next_timing_pin_config = timing_pin_config;
    next_timing_signal_select = timing_signal_select;
    next_pin_one_drive_control = pin_one_drive_control;
    if (reg_wr) begin
      case (reg_addr)
        TSP_ADDR_PIN_CONFIG: next_timing_pin_config = reg_wdata;
        TSP_ADDR_SIGNAL_SELECT: next_timing_signal_select = reg_wdata;
        TSP_ADDR_PIN_ONE_DRIVE: next_pin_one_drive_control = reg_wdata;
        default: next_timing_pin_config = timing_pin_config;
      endcase
    end
    case (reg_addr)
      TSP_ADDR_PIN_CONFIG: next_reg_rdata = timing_pin_config;
      TSP_ADDR_SIGNAL_SELECT: next_reg_rdata = timing_signal_select;
      TSP_ADDR_PIN_ONE_DRIVE: next_reg_rdata = pin_one_drive_control;
      default: next_reg_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      timing_pin_config <= TSP_PIN_CONFIG_RESET;
      timing_signal_select <= TSP_SIGNAL_SELECT_RESET;
      pin_one_drive_control <= TSP_PIN_ONE_DRIVE_RESET;
      reg_rdata <= 16'h0000;
    end else begin
      timing_pin_config <= next_timing_pin_config;
      timing_signal_select <= next_timing_signal_select;
      pin_one_drive_control <= next_pin_one_drive_control;
      reg_rdata <= next_reg_rdata;
    end
  end

  // The oscillator comes from another domain, so it is synchronised.
  // Its copy therefore lags by two cycles and jitters by one.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
    end else begin
      osc_meta <= osc_32k_pin;
      osc_sync <= osc_meta;
    end
  end

  // Sample sequencing for the written flags and the half-rate toggle.
  always_comb begin
    next_written_a = written_a;
    next_written_b = written_b;
    next_half_rate = half_rate;
    // A slot end with data stored wins over a coincident sample start.
    if (sample_start) begin
      next_written_a = 1'b0;
      next_written_b = 1'b0;
    end
    if (slot_a_end && data_stored_a) begin
      next_written_a = 1'b1;
    end
    if (slot_b_end && data_stored_b) begin
      next_written_b = 1'b1;
    end
    // A sample completes at the end of its last slot.
    if (slot_b_end || (slot_a_end && !slot_b_active)) begin
      next_half_rate = !half_rate;
    end
    if (normal_mode && !normal_q) begin
      next_half_rate = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      written_a <= 1'b0;
      written_b <= 1'b0;
      half_rate <= 1'b0;
      normal_q <= 1'b0;
    end else begin
      written_a <= next_written_a;
      written_b <= next_written_b;
      half_rate <= next_half_rate;
      normal_q <= normal_mode;
    end
  end

  assign legacy = (timing_signal_select == 16'h0000);
  assign sig.irq = irq_masked;
  assign sig.legacy_secondary_output = legacy_secondary_output;
  assign sig.window = slot_a_active | slot_b_active;
  assign sig.led_a = led_a_pulse;
  assign sig.led_b = led_b_pulse;
  assign sig.written_a = written_a;
  assign sig.written_b = written_b;
  assign sig.half_rate_toggle = half_rate;
  assign sig.osc = osc_sync;
  assign sel_zero = timing_signal_select[TSP_SEL0_LSB +: TSP_SEL_W];
  assign sel_one = timing_signal_select[TSP_SEL1_LSB +: TSP_SEL_W];

  tsp_pin_drive u_pin_zero (
    .clk(clk),
    .rst(rst),
    .sig(sig),
    .sel(sel_zero),
    .legacy(legacy),
    .legacy_is_pin_one(1'b0),
    .polarity_low(timing_pin_config[TSP_POL0_BIT]),
    .open_drain(timing_pin_config[TSP_STYLE0_BIT]),
    .drive_en(timing_pin_config[TSP_EN0_BIT]),
    .pin_out(timing_pin_zero_out),
    .pin_oe_n(timing_pin_zero_oe_n)
  );

  tsp_pin_drive u_pin_one (
    .clk(clk),
    .rst(rst),
    .sig(sig),
    .sel(sel_one),
    .legacy(legacy),
    .legacy_is_pin_one(1'b1),
    .polarity_low(timing_pin_config[TSP_POL1_BIT]),
    .open_drain(timing_pin_config[TSP_STYLE1_BIT]),
    .drive_en(pin_one_drive_control[TSP_EN1_BIT]),
    .pin_out(timing_pin_one_out),
    .pin_oe_n(timing_pin_one_oe_n)
  );

  property p_written_set;
    @(posedge clk) disable iff (rst)
      (slot_a_end && data_stored_a) |=> written_a;
  endproperty
  a_written_set: assert property (p_written_set)
    else $error("Written flag missed a stored slot end.");

  property p_written_clear;
    @(posedge clk) disable iff (rst)
      (sample_start && !slot_b_end) |=> !written_b;
  endproperty
  a_written_clear: assert property (p_written_clear)
    else $error("Written flag survived a new sample.");

  property p_half_start_low;
    @(posedge clk) disable iff (rst)
      (normal_mode && !normal_q) |=> !half_rate;
  endproperty
  a_half_start_low: assert property (p_half_start_low)
    else $error("Half-rate toggle did not start low.");

  property p_half_toggle;
    @(posedge clk) disable iff (rst)
      (slot_b_end && !(normal_mode && !normal_q))
        |=> half_rate != $past(half_rate);
  endproperty
  a_half_toggle: assert property (p_half_toggle)
    else $error("Half-rate toggle missed a sample end.");

  property p_legacy_pin_zero;
    @(posedge clk) disable iff (rst)
      (legacy && !timing_pin_config[TSP_POL0_BIT])
        |=> timing_pin_zero_out == $past(irq_masked);
  endproperty
  a_legacy_pin_zero: assert property (p_legacy_pin_zero)
    else $error("Legacy pin zero does not follow the interrupt.");

  property p_legacy_pin_one;
    @(posedge clk) disable iff (rst)
      (legacy && !timing_pin_config[TSP_POL1_BIT])
        |=> timing_pin_one_out == $past(legacy_secondary_output);
  endproperty
  a_legacy_pin_one: assert property (p_legacy_pin_one)
    else $error("Legacy pin one does not follow its source.");

  property p_irq_route;
    @(posedge clk) disable iff (rst)
      (sel_zero == TSP_SEL_INTERRUPT && !timing_pin_config[TSP_POL0_BIT])
        |=> timing_pin_zero_out == $past(irq_masked);
  endproperty
  a_irq_route: assert property (p_irq_route)
    else $error("Interrupt selection shows the wrong level.");

  property p_window_route;
    @(posedge clk) disable iff (rst)
      (sel_one == TSP_SEL_SAMPLE_WINDOW && !timing_pin_config[TSP_POL1_BIT])
        |=> timing_pin_one_out == $past(slot_a_active | slot_b_active);
  endproperty
  a_window_route: assert property (p_window_route)
    else $error("Sample window selection shows the wrong level.");

  property p_led_route;
    @(posedge clk) disable iff (rst)
      (sel_zero == TSP_SEL_LED_AB && !timing_pin_config[TSP_POL0_BIT])
        |=> timing_pin_zero_out == $past(led_a_pulse | led_b_pulse);
  endproperty
  a_led_route: assert property (p_led_route)
    else $error("LED copy selection shows the wrong level.");

  property p_written_route;
    @(posedge clk) disable iff (rst)
      (sel_one == TSP_SEL_WRITTEN_AB && !timing_pin_config[TSP_POL1_BIT])
        |=> timing_pin_one_out == $past(written_a | written_b);
  endproperty
  a_written_route: assert property (p_written_route)
    else $error("Written selection shows the wrong level.");

  property p_half_route;
    @(posedge clk) disable iff (rst)
      (sel_zero == TSP_SEL_HALF_RATE && !timing_pin_config[TSP_POL0_BIT])
        |=> timing_pin_zero_out == $past(half_rate);
  endproperty
  a_half_route: assert property (p_half_route)
    else $error("Half-rate selection shows the wrong level.");

  property p_osc_route;
    @(posedge clk) disable iff (rst)
      (sel_one == TSP_SEL_OSC && !timing_pin_config[TSP_POL1_BIT])
        |=> timing_pin_one_out == $past(osc_sync);
  endproperty
  a_osc_route: assert property (p_osc_route)
    else $error("Oscillator selection shows the wrong level.");

  property p_pin_one_disabled;
    @(posedge clk) disable iff (rst)
      !pin_one_drive_control[TSP_EN1_BIT] |=> timing_pin_one_oe_n;
  endproperty
  a_pin_one_disabled: assert property (p_pin_one_disabled)
    else $error("Pin one driven while its drive is disabled.");

  property p_push_pull_zero;
    @(posedge clk) disable iff (rst)
      (timing_pin_config[TSP_EN0_BIT] && !timing_pin_config[TSP_STYLE0_BIT])
        |=> !timing_pin_zero_oe_n;
  endproperty
  a_push_pull_zero: assert property (p_push_pull_zero)
    else $error("Push-pull pin zero is not driven.");

  property p_select_write;
    @(posedge clk) disable iff (rst)
      (reg_wr && reg_addr == TSP_ADDR_SIGNAL_SELECT)
        |=> timing_signal_select == $past(reg_wdata);
  endproperty
  a_select_write: assert property (p_select_write)
    else $error("Select register did not take the written word.");

  property p_polarity_low;
    @(posedge clk) disable iff (rst)
      (sel_one == TSP_SEL_LOGIC_ZERO && timing_pin_config[TSP_POL1_BIT])
        |=> timing_pin_one_out;
  endproperty
  a_polarity_low: assert property (p_polarity_low)
    else $error("Active-low pin one is not high while inactive.");
endmodule
`default_nettype wire

//--- dv/tsp_host_model.sv
// Far-side host model that resolves the two timing pin wires.
`default_nettype none
module tsp_host_model (
  input wire logic out0,
  input wire logic oe0_n,
  input wire logic out1,
  input wire logic oe1_n,
  output logic line0,
  output logic line1
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pull-ups hold a released wire high, so open drain reads correctly.
  assign line0 = oe0_n ? 1'b1 : out0;
  assign line1 = oe1_n ? 1'b1 : out1;
endmodule
`default_nettype wire

//--- dv/tb.sv
// Self-checking bench for the timing signal pin selector.
`default_nettype none
module tb;
  import tsp_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0000;
  logic [15:0] rd;
  logic [9:0] lv = 10'h000;
  logic [2:0] ev = 3'h0;
  logic o0, e0, o1, e1, l0, l1;
  logic chk = 1'b0;
  logic [16:0] q[$];
  logic [16:0] ex, got;
  logic [31:0] seed = 32'h1C3D7F2E;
  int error_cnt = 0;
  int n_tests = 0;
  logic [15:0] cfg, sel, drv1;
  logic wa, wb, hr;
  logic [4:0] codes [16] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h05, 5'h06,
    5'h07, 5'h0C, 5'h0D, 5'h0E, 5'h0F, 5'h10, 5'h11, 5'h13, 5'h1A, 5'h1F};
  always #10 clk = ~clk;
  tsp_timing_pins u_dut (
    .clk(clk), .rst(rst), .reg_wr(wr), .reg_addr(addr), .reg_wdata(wd),
    .reg_rdata(rd), .normal_mode(lv[9]), .sample_start(ev[0]),
    .slot_a_active(lv[0]), .slot_b_active(lv[1]), .slot_a_end(ev[1]),
    .slot_b_end(ev[2]), .led_a_pulse(lv[2]), .led_b_pulse(lv[3]),
    .data_stored_a(lv[4]), .data_stored_b(lv[5]), .irq_masked(lv[6]),
    .legacy_secondary_output(lv[7]), .osc_32k_pin(lv[8]),
    .timing_pin_zero_out(o0), .timing_pin_zero_oe_n(e0),
    .timing_pin_one_out(o1), .timing_pin_one_oe_n(e1));
  tsp_host_model u_host (.out0(o0), .oe0_n(e0), .out1(o1), .oe1_n(e1),
    .line0(l0), .line1(l1));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  function automatic logic asrt(input logic [4:0] c, input logic lg,
    input logic one);
    if (lg) return one ? lv[7] : lv[6];
    case (c)
      TSP_SEL_INTERRUPT: return lv[6];
      TSP_SEL_SAMPLE_WINDOW: return lv[0] | lv[1];
      TSP_SEL_LED_A: return lv[2];
      TSP_SEL_LED_B: return lv[3];
      TSP_SEL_LED_AB: return lv[2] | lv[3];
      TSP_SEL_WRITTEN_A: return wa;
      TSP_SEL_WRITTEN_B: return wb;
      TSP_SEL_WRITTEN_AB: return wa | wb;
      TSP_SEL_HALF_RATE: return hr;
      TSP_SEL_LOGIC_ONE: return 1'b1;
      TSP_SEL_OSC: return lv[8];
      default: return 1'b0;
    endcase
  endfunction
  // Polarity sets only the driven level; open drain releases whenever not asserted.
  function automatic logic [2:0] pinx(input logic a, p, od, en);
    logic oe;
    oe = !en | (od & !a);
    return {a ^ p, oe, oe | (a ^ p)};
  endfunction
  function automatic logic [16:0] expv();
    logic lg;
    lg = (sel == 16'h0000);
    return {11'h000, pinx(asrt(sel[4:0], lg, 1'b0), cfg[0], cfg[1], cfg[2]),
      pinx(asrt(sel[12:8], lg, 1'b1), cfg[8], cfg[9], drv1[6])};
  endfunction
  task automatic check(input logic [16:0] e);
    @(posedge clk);
    q.push_back(e);
    chk <= 1'b1;
    @(posedge clk);
    chk <= 1'b0;
  endtask
  task automatic wreg(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [7:0] a, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    check({1'b1, e});
  endtask
  task automatic setup();
    wreg(TSP_ADDR_PIN_CONFIG, cfg);
    wreg(TSP_ADDR_SIGNAL_SELECT, sel);
    wreg(TSP_ADDR_PIN_ONE_DRIVE, drv1);
  endtask
  task automatic pulse(input logic [2:0] m);
    @(posedge clk);
    ev <= m;
    @(posedge clk);
    ev <= 3'h0;
  endtask
  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(negedge clk) begin
    if (chk) begin
      ex = q.pop_front();
      got = ex[16] ? {1'b1, rd} : {11'h000, o0, e0, l0, o1, e1, l1};
      n_tests++;
      if (got !== ex) begin
        error_cnt++;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, ex);
      end
    end
  end
  // A hang is cut short well beyond the roughly 850 cycles the run needs.
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    close_out();
  end
  initial begin
    cfg = 16'h0000;
    sel = 16'h0000;
    drv1 = 16'h0000;
    wa = 1'b0;
    wb = 1'b0;
    hr = 1'b0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    wreg(8'h33, 16'hFFFF);
    rreg(8'h33, 16'h0000);
    rreg(TSP_ADDR_PIN_CONFIG, TSP_PIN_CONFIG_RESET);
    rreg(TSP_ADDR_SIGNAL_SELECT, TSP_SIGNAL_SELECT_RESET);
    rreg(TSP_ADDR_PIN_ONE_DRIVE, TSP_PIN_ONE_DRIVE_RESET);
    check(expv());
    for (int i = 0; i < 64; i++) begin
      seed = xs(seed);
      cfg = {6'h00, seed[9:8], 5'h00, seed[2:0]};
      drv1 = {9'h000, seed[3], 6'h00};
      sel = {3'h0, codes[seed[15:12]], 3'h0, codes[seed[19:16]]};
      @(posedge clk);
      lv <= {1'b0, seed[28:20]};
      setup();
      rreg(TSP_ADDR_SIGNAL_SELECT, sel);
      check(expv());
    end
    // Interrupt high and secondary low, so swapped legacy pins show.
    sel = 16'h0000;
    @(posedge clk);
    lv <= 10'h040;
    setup();
    check(expv());
    cfg = 16'h0004;
    drv1 = 16'h0040;
    sel = {3'h0, TSP_SEL_WRITTEN_B, 3'h0, TSP_SEL_WRITTEN_A};
    @(posedge clk);
    lv <= 10'h230;
    setup();
    pulse(3'b010);
    wa = 1'b1;
    hr = 1'b1;
    check(expv());
    pulse(3'b100);
    wb = 1'b1;
    hr = 1'b0;
    check(expv());
    sel = {3'h0, TSP_SEL_WRITTEN_AB, 3'h0, TSP_SEL_HALF_RATE};
    setup();
    check(expv());
    pulse(3'b001);
    wa = 1'b0;
    wb = 1'b0;
    check(expv());
    pulse(3'b101);
    wb = 1'b1;
    hr = 1'b1;
    check(expv());
    @(posedge clk);
    lv <= 10'h030;
    @(posedge clk);
    lv <= 10'h230;
    hr = 1'b0;
    // The toggle clears one edge after the rise, the pin one edge later.
    @(posedge clk);
    check(expv());
    close_out();
  end
endmodule
`default_nettype wire
